// ==== include/tmr_params.svh ====
// Purpose: Named constants for the 16-bit capture/compare timer.
// Assumes: Included by its bare name; definitions only.
// Notes:   Mode codes, reset values and prescaler masks live here.
`ifndef TMR_PARAMS_SVH
`define TMR_PARAMS_SVH

// Widths of the counter, a register byte and the prescaler.
`define TMR_CNT_W        16
`define TMR_BYTE_W       8
`define TMR_PRESC_W      10
`define TMR_SYNC_STAGES  2

// Reset and clear values.
`define TMR_CNT_ZERO     16'h0000
`define TMR_CMP_RST      16'hffff
`define TMR_HOLD_RST     8'hff
`define TMR_BYTE_ZERO    8'h00
`define TMR_PRESC_ZERO   10'h000
`define TMR_PRESC_ONE    10'h001
`define TMR_CNT_ONE      16'h0001

// Mode field codes.
`define TMR_MODE_TIMER0  3'h0
`define TMR_MODE_TIMER1  3'h1
`define TMR_MODE_EVENT   3'h2
`define TMR_MODE_EXTTRIG 3'h4

// Source clock select codes and their prescaler terminal masks.
`define TMR_CK_DIV1024   2'h0
`define TMR_CK_DIV64     2'h1
`define TMR_CK_DIV4      2'h2
`define TMR_CK_DIV2      2'h3
`define TMR_MASK_DIV1024 10'h3ff
`define TMR_MASK_DIV64   10'h03f
`define TMR_MASK_DIV4    10'h003
`define TMR_MASK_DIV2    10'h001

// Single-bit selector meanings.
`define TMR_EDGE_RISE    1'b0
`define TMR_METT_STOP    1'b1
`define TMR_DBF_ON       1'b1

`endif

// ==== include/tmr_pkg.sv ====
// Purpose: Types shared by the timer design files.
// Assumes: tmr_params.svh supplies the widths.
// Notes:   The whole module state is one packed struct.
`include "tmr_params.svh"

package tmr_pkg;

	// Counting phase; one-hot codes.
	typedef enum logic [1:0] {
		TMR_PH_WAIT  = 2'b01,
		TMR_PH_COUNT = 2'b10
	} tmr_phase_e;

	// Complete state of the timer core.
	typedef struct packed {
		logic                       run;
		logic                       cap_en;
		logic                       dbf;
		logic                       ove;
		logic [2:0]                 mode;
		logic [1:0]                 cksel;
		logic                       ted;
		logic                       mett;
		tmr_phase_e                 phase;
		logic [`TMR_CNT_W-1:0]      count;
		logic [`TMR_BYTE_W-1:0]     hold;
		logic [`TMR_CNT_W-1:0]      dbuf;
		logic [`TMR_CNT_W-1:0]      cmp;
		logic                       pend;
		logic [`TMR_CNT_W-1:0]      capb;
		logic [`TMR_BYTE_W-1:0]     b_lo_out;
		logic [`TMR_CNT_W-1:0]      a_out;
		logic                       irq;
		logic [`TMR_PRESC_W-1:0]    presc;
	} tmr_state_s;

	// State of the pin synchroniser and edge detector.
	typedef struct packed {
		logic [`TMR_SYNC_STAGES-1:0] sync;
		logic                        prev;
		logic                        rise;
		logic                        fall;
	} tmr_sync_s;

endpackage

// ==== design/tmr_edge_sync.sv ====
// Purpose: Synchronise the trigger pin and detect its edges.
// Assumes: Pin may change at any time; clk is the timer clock.
// Notes:   Edge pulses are registered and last one cycle.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_params.svh"

module tmr_edge_sync
	import tmr_pkg::*;
#(
	parameter int STAGES = `TMR_SYNC_STAGES
) (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic srst,
	// Raw pin.
	input  wire logic pin,
	// Edge pulses.
	output logic      rise,
	output logic      fall
);

	tmr_sync_s st_reg;
	tmr_sync_s st_next;

	// Refuse stage counts the struct does not carry.
	initial begin
		if (STAGES != `TMR_SYNC_STAGES) begin
			$error("tmr_edge_sync: STAGES must match the struct width.");
		end
	end

	// Shift the pin in; only the last stage feeds the edge compare.
	always_comb begin
		st_next      = st_reg;
		st_next.sync = {st_reg.sync[`TMR_SYNC_STAGES-2:0], pin};
		st_next.prev = st_reg.sync[`TMR_SYNC_STAGES-1];
		st_next.rise = st_reg.sync[`TMR_SYNC_STAGES-1] & ~st_reg.prev;
		st_next.fall = ~st_reg.sync[`TMR_SYNC_STAGES-1] & st_reg.prev;
	end

	// Register the state; a slow pin keeps one pulse per edge.
	always_ff @(posedge clk) begin
		if (srst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs come straight from the registers.
	assign rise = st_reg.rise;
	assign fall = st_reg.fall;

endmodule
`default_nettype wire

// ==== design/tmr_timer16.sv ====
// Purpose: 16-bit up-counter timer with auto capture and buffered compare.
// Assumes: Processor strobes are synchronous one-cycle pulses on clk.
// Notes:   Timer, external-trigger and event-counter modes are served.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_params.svh"

module tmr_timer16
	import tmr_pkg::*;
#(
	parameter int CNT_W = `TMR_CNT_W
) (
	// Clock and reset.
	input  wire logic                    clk,
	input  wire logic                    srst,
	// Control register write.
	input  wire logic                    ctrl_wr,
	input  wire logic                    ctrl_run_bit,
	input  wire logic                    ctrl_capture_enable,
	input  wire logic                    ctrl_double_buffer_enable,
	input  wire logic                    ctrl_overflow_irq_enable,
	// Mode register write.
	input  wire logic                    mode_wr,
	input  wire logic [2:0]              mode_field_in,
	input  wire logic [1:0]              source_clock_select_in,
	input  wire logic                    edge_select_in,
	input  wire logic                    trigger_mode_bit_in,
	// Compare register access.
	input  wire logic                    compare_a_low_wr,
	input  wire logic                    compare_a_high_wr,
	input  wire logic [`TMR_BYTE_W-1:0]  wr_byte,
	input  wire logic                    compare_b_low_rd,
	// External trigger or event pin.
	input  wire logic                    trigger_input_pin,
	// Status and read data.
	output logic                         run_bit,
	output logic                         capture_enable,
	output logic                         double_buffer_enable,
	output logic                         overflow_irq_enable,
	output logic [2:0]                   mode_field,
	output logic [`TMR_CNT_W-1:0]        compare_reg_a,
	output logic [`TMR_BYTE_W-1:0]       compare_b_low,
	output logic [`TMR_BYTE_W-1:0]       compare_b_high,
	output logic [`TMR_CNT_W-1:0]        count,
	output logic                         timer_interrupt
);

	// Byte-wide register access only fits a 16-bit counter.
	initial begin
		if (CNT_W != 2 * `TMR_BYTE_W) begin
			$error("tmr_timer16: CNT_W must be two bytes.");
		end
	end

	// Pick the rising or falling pulse named by an edge selector.
	function automatic logic sel_edge(input logic ted, input logic r, input logic f);
		sel_edge = (ted == `TMR_EDGE_RISE) ? r : f;
	endfunction

	// Terminal mask of the prescaler for a source clock select.
	function automatic logic [`TMR_PRESC_W-1:0] sel_mask(input logic [1:0] ck);
		case (ck)
			`TMR_CK_DIV1024: sel_mask = `TMR_MASK_DIV1024;
			`TMR_CK_DIV64:   sel_mask = `TMR_MASK_DIV64;
			`TMR_CK_DIV4:    sel_mask = `TMR_MASK_DIV4;
			default:         sel_mask = `TMR_MASK_DIV2;
		endcase
	endfunction

	localparam tmr_state_s ST_RST = '{
		run:      1'b0,
		cap_en:   1'b0,
		dbf:      1'b0,
		ove:      1'b0,
		mode:     `TMR_MODE_TIMER0,
		cksel:    `TMR_CK_DIV1024,
		ted:      `TMR_EDGE_RISE,
		mett:     1'b0,
		phase:    TMR_PH_WAIT,
		count:    `TMR_CNT_ZERO,
		hold:     `TMR_HOLD_RST,
		dbuf:     `TMR_CMP_RST,
		cmp:      `TMR_CMP_RST,
		pend:     1'b0,
		capb:     `TMR_CMP_RST,
		b_lo_out: `TMR_HOLD_RST,
		a_out:    `TMR_CMP_RST,
		irq:      1'b0,
		presc:    `TMR_PRESC_ZERO
	};

	tmr_state_s             st_reg;
	tmr_state_s             st_next;
	logic                   pin_rise;
	logic                   pin_fall;
	logic                   start_edge;
	logic                   stop_edge;
	logic                   tick;
	logic                   inc;
	logic                   counting;
	logic [`TMR_CNT_W-1:0]  a_val;

	// Pin edges arrive as clean one-cycle pulses.
	tmr_edge_sync u_sync (
		.clk  (clk),
		.srst (srst),
		.pin  (trigger_input_pin),
		.rise (pin_rise),
		.fall (pin_fall)
	);

	// Edge selection, source clock tick and increment request.
	assign start_edge = sel_edge(st_reg.ted, pin_rise, pin_fall);
	assign stop_edge  = sel_edge(~st_reg.ted, pin_rise, pin_fall);
	assign tick       = (st_reg.presc & sel_mask(st_reg.cksel)) == sel_mask(st_reg.cksel);
	assign counting   = st_reg.run && (st_reg.phase == TMR_PH_COUNT);
	assign inc        = counting && ((st_reg.mode == `TMR_MODE_EVENT) ? start_edge : tick);
	assign a_val      = {wr_byte, st_reg.hold};

	// Next-state logic for control, counting, compare and capture.
	always_comb begin
		st_next     = st_reg;
		st_next.irq = 1'b0;

		// Control write; a stopping write keeps the old capture enable.
		if (ctrl_wr) begin
			if (st_reg.run && !ctrl_run_bit) begin
				st_next.run = 1'b0;
			end else begin
				st_next.run    = ctrl_run_bit;
				st_next.cap_en = ctrl_capture_enable;
			end
			st_next.dbf = ctrl_double_buffer_enable;
			if (!st_reg.run) begin
				st_next.ove = ctrl_overflow_irq_enable;
			end
		end

		// Mode register is only taken while stopped.
		if (mode_wr && !st_reg.run) begin
			st_next.mode  = mode_field_in;
			st_next.cksel = source_clock_select_in;
			st_next.ted   = edge_select_in;
			st_next.mett  = trigger_mode_bit_in;
		end

		// Counter sequencing.
		if (!st_next.run) begin
			st_next.phase = TMR_PH_WAIT;
			st_next.count = `TMR_CNT_ZERO;
			st_next.presc = `TMR_PRESC_ZERO;
		end else if (!st_reg.run) begin
			// Start: the external-trigger mode waits for its edge.
			case (st_reg.mode)
				`TMR_MODE_TIMER0,
				`TMR_MODE_TIMER1,
				`TMR_MODE_EVENT:   st_next.phase = TMR_PH_COUNT;
				default:           st_next.phase = TMR_PH_WAIT;
			endcase
		end else begin
			case (st_reg.phase)
				TMR_PH_WAIT: begin
					if (st_reg.mode == `TMR_MODE_EXTTRIG && start_edge) begin
						st_next.phase = TMR_PH_COUNT;
						st_next.presc = `TMR_PRESC_ZERO;
					end
				end
				TMR_PH_COUNT: begin
					st_next.presc = st_reg.presc + `TMR_PRESC_ONE;
					if (inc) begin
						if (st_reg.count == st_reg.cmp) begin
							st_next.irq   = 1'b1;
							st_next.count = `TMR_CNT_ZERO;
							if (st_reg.pend) begin
								st_next.cmp  = st_reg.dbuf;
								st_next.pend = 1'b0;
							end
						end else begin
							st_next.count = st_reg.count + `TMR_CNT_ONE;
						end
					end
					// With the trigger-mode bit low, pin edges do nothing here.
					if (st_reg.mode == `TMR_MODE_EXTTRIG && st_reg.mett == `TMR_METT_STOP &&
						stop_edge) begin
						st_next.phase = TMR_PH_WAIT;
						st_next.count = `TMR_CNT_ZERO;
						st_next.presc = `TMR_PRESC_ZERO;
					end
				end
				default: st_next.phase = TMR_PH_WAIT;
			endcase
		end

		// Low compare-A byte only parks in the holding buffer.
		if (compare_a_low_wr) begin
			st_next.hold = wr_byte;
		end

		// High compare-A byte commits both bytes by the buffer policy.
		if (compare_a_high_wr) begin
			if (!st_reg.run) begin
				st_next.cmp = a_val;
				if (st_reg.dbf == `TMR_DBF_ON) begin
					st_next.dbuf = a_val;
				end
			end else if (st_reg.dbf == `TMR_DBF_ON) begin
				st_next.dbuf = a_val;
				st_next.pend = 1'b1;
			end else begin
				st_next.cmp = a_val;
			end
		end

		// Dropping the double buffer leaves nothing waiting.
		if (st_next.dbf != `TMR_DBF_ON) begin
			st_next.pend = 1'b0;
		end

		// Auto capture on a low-B read; low byte first, then high.
		if (compare_b_low_rd) begin
			if (st_reg.cap_en) begin
				if (st_reg.run) begin
					st_next.b_lo_out = st_reg.count[`TMR_BYTE_W-1:0];
					st_next.capb     = st_reg.count;
				end else begin
					st_next.b_lo_out = `TMR_BYTE_ZERO;
					st_next.capb     = `TMR_CNT_ZERO;
				end
			end else begin
				st_next.b_lo_out = st_reg.capb[`TMR_BYTE_W-1:0];
			end
		end

		// Compare-A read image follows the buffer policy.
		st_next.a_out = (st_next.dbf == `TMR_DBF_ON) ? st_next.dbuf : st_next.cmp;
	end

	// State register; reset fills the compare buffers with ones.
	always_ff @(posedge clk) begin
		if (srst) begin
			st_reg <= ST_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs come straight from the state register.
	assign run_bit              = st_reg.run;
	assign capture_enable       = st_reg.cap_en;
	assign double_buffer_enable = st_reg.dbf;
	assign overflow_irq_enable  = st_reg.ove;
	assign mode_field           = st_reg.mode;
	assign compare_reg_a        = st_reg.a_out;
	assign compare_b_low        = st_reg.b_lo_out;
	assign compare_b_high       = st_reg.capb[CNT_W-1:`TMR_BYTE_W];
	assign count                = st_reg.count;
	assign timer_interrupt      = st_reg.irq;

	// Live capture returns the count seen at the read.
	a_cap_live: assert property (@(posedge clk) disable iff (srst)
		compare_b_low_rd && st_reg.cap_en && st_reg.run |=>
		{compare_b_high, compare_b_low} == $past(st_reg.count))
		else $error("Auto capture did not return the live count.");

	// Stopped capture reads zero in both bytes.
	a_cap_stopped: assert property (@(posedge clk) disable iff (srst)
		compare_b_low_rd && st_reg.cap_en && !st_reg.run |=> {compare_b_high, compare_b_low} == `TMR_CNT_ZERO)
		else $error("Stopped capture did not read zero.");

	// Low-A write alone never moves the compare value.
	a_hold_only: assert property (@(posedge clk) disable iff (srst)
		compare_a_low_wr && !compare_a_high_wr && !inc |=> st_reg.cmp == $past(st_reg.cmp))
		else $error("Low compare byte reached the compare value.");

	// Buffered running write waits in the double buffer.
	a_dbuf_wait: assert property (@(posedge clk) disable iff (srst)
		compare_a_high_wr && st_reg.run && st_reg.dbf && !inc && !ctrl_wr |=>
		st_reg.cmp == $past(st_reg.cmp) && st_reg.dbuf == {$past(wr_byte), $past(st_reg.hold)} && st_reg.pend)
		else $error("Buffered compare write did not wait.");

	// Stopped or unbuffered writes load the compare value at once.
	a_direct_load: assert property (@(posedge clk) disable iff (srst)
		compare_a_high_wr && (!st_reg.run || !st_reg.dbf) && !inc |=>
		st_reg.cmp == {$past(wr_byte), $past(st_reg.hold)})
		else $error("Compare write did not take effect at once.");

	// Read image of compare A tracks the buffer policy.
	a_rd_image: assert property (@(posedge clk) disable iff (srst)
		compare_reg_a == (st_reg.dbf ? st_reg.dbuf : st_reg.cmp))
		else $error("Compare A read image is wrong.");

	// A stopping write keeps capture enable and clears the count.
	a_stop_write: assert property (@(posedge clk) disable iff (srst)
		ctrl_wr && st_reg.run && !ctrl_run_bit |=> st_reg.cap_en == $past(st_reg.cap_en) && count == `TMR_CNT_ZERO)
		else $error("Stopping write misbehaved.");

	// Mode writes are dropped while running.
	a_mode_lock: assert property (@(posedge clk) disable iff (srst)
		mode_wr && st_reg.run |=> mode_field == $past(mode_field) && st_reg.ted == $past(st_reg.ted))
		else $error("Mode changed while running.");

	// A match raises one interrupt and restarts from zero.
	a_match_irq: assert property (@(posedge clk) disable iff (srst)
		inc && st_reg.count == st_reg.cmp && !ctrl_wr |=> timer_interrupt && count == `TMR_CNT_ZERO ##1 !timer_interrupt)
		else $error("Compare match was not handled.");

	// Opposite edge stops the triggered counter when so configured.
	a_trig_stop: assert property (@(posedge clk) disable iff (srst)
		counting && st_reg.mode == `TMR_MODE_EXTTRIG && st_reg.mett && stop_edge && !ctrl_wr |=>
		count == `TMR_CNT_ZERO && st_reg.phase == TMR_PH_WAIT)
		else $error("Opposite trigger edge did not stop the counter.");

endmodule
`default_nettype wire

// ==== test/tmr_pin_model.sv ====
// Purpose: Model of the pulse source that drives the trigger pin.
// Assumes: The bench states the wanted level on want.
// Notes:   Each level is held at least three cycles.
`timescale 1ns/1ps
`default_nettype none

module tmr_pin_model (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic srst,
	// Requested level.
	input  wire logic want,
	// Driven pin.
	output var logic  pin
);
	logic [1:0] age_reg;

	// A change waits until the old level is old enough.
	always_ff @(posedge clk) begin
		if (srst) begin
			pin     <= 1'b0;
			age_reg <= 2'h0;
		end else if (age_reg != 2'h2) begin
			age_reg <= age_reg + 2'h1;
		end else if (want != pin) begin
			pin     <= want;
			age_reg <= 2'h0;
		end
	end
endmodule
`default_nettype wire

// ==== test/tmr_timer16_tb_top.sv ====
// Purpose: Self-checking bench for the capture/compare timer.
// Assumes: Strobes are one-cycle pulses driven 1 ns after the edge.
// Notes:   Divide-by-2 source clock keeps the run short.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_params.svh"

module tmr_timer16_tb_top;
	logic        clk, srst, cwr, crun, ccap, cdbf, cove, mwr;
	logic [2:0]  mfi;
	logic [1:0]  cki;
	logic        tedi, metti, alw, ahw, brd, want, pin;
	logic [7:0]  wb, compare_b_low, compare_b_high;
	logic        run_bit, capture_enable, double_buffer_enable;
	logic        overflow_irq_enable, timer_interrupt;
	logic [2:0]  mode_field;
	logic [15:0] compare_reg_a, count, snap, pk;
	int          mismatches, tests_run;

	// Device under test.
	tmr_timer16 dut (.clk(clk), .srst(srst), .ctrl_wr(cwr), .ctrl_run_bit(crun),
		.ctrl_capture_enable(ccap), .ctrl_double_buffer_enable(cdbf),
		.ctrl_overflow_irq_enable(cove), .mode_wr(mwr), .mode_field_in(mfi),
		.source_clock_select_in(cki), .edge_select_in(tedi), .trigger_mode_bit_in(metti),
		.compare_a_low_wr(alw), .compare_a_high_wr(ahw), .wr_byte(wb),
		.compare_b_low_rd(brd), .trigger_input_pin(pin), .run_bit(run_bit),
		.capture_enable(capture_enable), .double_buffer_enable(double_buffer_enable),
		.overflow_irq_enable(overflow_irq_enable), .mode_field(mode_field),
		.compare_reg_a(compare_reg_a), .compare_b_low(compare_b_low),
		.compare_b_high(compare_b_high), .count(count), .timer_interrupt(timer_interrupt));

	// Far-side pulse source.
	tmr_pin_model src (.clk(clk), .srst(srst), .want(want), .pin(pin));

	// Free-running 250 MHz clock.
	always #2 clk = ~clk;

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic end_sim;
		$display("Checks %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// The write strobe tasks let one idle edge pass, so a following call never re-raises a strobe in the same step.
	task automatic cw(input logic r, input logic c, input logic d, input logic o);
		{crun, ccap, cdbf, cove} = {r, c, d, o};
		cwr = 1'b1;
		cyc(1);
		cwr = 1'b0;
		cyc(1);
	endtask

	task automatic mw(input logic [2:0] m, input logic t, input logic mt);
		{mfi, tedi, metti} = {m, t, mt};
		mwr = 1'b1;
		cyc(1);
		mwr = 1'b0;
		cyc(1);
	endtask

	task automatic wlo(input logic [7:0] v);
		wb = v;
		alw = 1'b1;
		cyc(1);
		alw = 1'b0;
		cyc(1);
	endtask

	task automatic whi(input logic [7:0] v);
		wb = v;
		ahw = 1'b1;
		cyc(1);
		ahw = 1'b0;
		cyc(1);
	endtask

	task automatic wa(input logic [15:0] v);
		wlo(v[7:0]);
		whi(v[15:8]);
	endtask

	// Capture read: snap holds the count that the read edge sees.
	task automatic rdb;
		snap = count;
		brd = 1'b1;
		cyc(1);
		brd = 1'b0;
	endtask

	task automatic tog;
		want = ~want;
		cyc(10);
	endtask

	// Waits for a match pulse and returns the highest count seen before it.
	task automatic wirq(output logic [15:0] p);
		int i;
		p = 16'h0000;
		// A pulse still standing from the previous match is let go by first.
		if (timer_interrupt === 1'b1) cyc(1);
		for (i = 0; i < 1000 && timer_interrupt !== 1'b1; i++) begin
			if (count > p) p = count;
			cyc(1);
		end
		if (timer_interrupt !== 1'b1) begin
			mismatches++;
			$display("BAD irq expected 1 seen %b", timer_interrupt);
			end_sim();
		end else begin
			chk("count_at_match", 16'h0000, count);
		end
	endtask

	task automatic t_load;
		chk("rst_a", 16'hffff, compare_reg_a);
		chk("rst_b", 16'hffff, {compare_b_high, compare_b_low});
		whi(8'h12);
		chk("hold_rst", 16'h12ff, compare_reg_a);
		wlo(8'h34);
		chk("low_only", 16'h12ff, compare_reg_a);
		whi(8'h12);
		chk("pair", 16'h1234, compare_reg_a);
		$display("Test load done");
	endtask

	task automatic t_capture;
		mw(`TMR_MODE_TIMER0, 1'b0, 1'b0);
		wa(16'h0400);
		cw(1'b1, 1'b1, 1'b0, 1'b0);
		chk("run_on", 16'h0001, {15'h0, run_bit});
		rdb();
		chk("cap_start", snap, {compare_b_high, compare_b_low});
		cyc(600);
		rdb();
		chk("cap_run", snap, {compare_b_high, compare_b_low});
		mw(`TMR_MODE_EVENT, 1'b1, 1'b1);
		chk("mode_lock", 16'h0000, {13'h0, mode_field});
		cw(1'b1, 1'b1, 1'b0, 1'b1);
		chk("ove_lock", 16'h0000, {15'h0, overflow_irq_enable});
		cw(1'b0, 1'b0, 1'b0, 1'b0);
		chk("cap_kept", 16'h0001, {15'h0, capture_enable});
		chk("stop_clr", 16'h0000, count);
		chk("run_off", 16'h0000, {15'h0, run_bit});
		chk("high_kept", {8'h00, snap[15:8]}, {8'h00, compare_b_high});
		rdb();
		chk("cap_stop", 16'h0000, {compare_b_high, compare_b_low});
		$display("Test capture done");
	endtask

	task automatic t_dbf;
		// The second timer code and a slower source clock are taken here.
		cki = `TMR_CK_DIV4;
		mw(`TMR_MODE_TIMER1, 1'b0, 1'b0);
		cki = `TMR_CK_DIV2;
		cw(1'b0, 1'b1, 1'b1, 1'b0);
		chk("dbf_on", 16'h0001, {15'h0, double_buffer_enable});
		wa(16'h0005);
		chk("dbf_stop", 16'h0005, compare_reg_a);
		cw(1'b1, 1'b1, 1'b1, 1'b0);
		wa(16'h0002);
		chk("dbf_read", 16'h0002, compare_reg_a);
		wirq(pk);
		chk("old_cmp", 16'h0005, pk);
		wirq(pk);
		chk("new_cmp", 16'h0002, pk);
		cw(1'b1, 1'b1, 1'b0, 1'b0);
		wirq(pk);
		wa(16'h0009);
		wirq(pk);
		chk("direct_cmp", 16'h0009, pk);
		cw(1'b0, 1'b1, 1'b0, 1'b0);
		$display("Test double buffer done");
	endtask

	task automatic t_event;
		int t;
		for (t = 0; t < 2; t++) begin
			mw(`TMR_MODE_EVENT, t[0], 1'b0);
			wa(16'h0002);
			cw(1'b1, 1'b1, 1'b0, 1'b0);
			// The pin starts opposite the counted edge, so two of four toggles count.
			repeat (4) tog();
			chk("evt_count", 16'h0002, count);
			// The fifth toggle is a counted edge that meets the compare value.
			want = ~want;
			wirq(pk);
			chk("evt_peak", 16'h0002, pk);
			cw(1'b0, 1'b1, 1'b0, 1'b0);
		end
		$display("Test event done");
	endtask

	task automatic t_trig;
		int t, k;
		logic [2:0] e;
		for (t = 0; t < 2; t++) begin
			e = t[0] ? 3'b110 : 3'b101;
			mw(`TMR_MODE_EXTTRIG, t[0], ~t[0]);
			wa(16'h0200);
			cw(1'b1, 1'b1, 1'b0, 1'b0);
			cyc(10);
			chk("trig_wait", 16'h0000, count);
			for (k = 0; k < 3; k++) begin
				tog();
				chk("trig_run", {15'h0, e[k]}, {15'h0, count != 16'h0000});
			end
			cw(1'b0, 1'b1, 1'b0, 1'b0);
			tog();
		end
		$display("Test trigger done");
	endtask

	// Reset, then the scenarios in turn.
	initial begin
		{clk, cwr, crun, ccap, cdbf, cove, mwr, tedi, metti, alw, ahw, brd, want} = '0;
		{mfi, wb} = '0;
		cki = `TMR_CK_DIV2;
		mismatches = 0;
		tests_run = 0;
		srst = 1'b1;
		repeat (20) @(posedge clk);
		#1;
		srst = 1'b0;
		cyc(1);
		t_load();
		t_capture();
		t_dbf();
		t_event();
		t_trig();
		end_sim();
	end
endmodule
`default_nettype wire
